// ---- shared/tec_pkg.sv ----
package tec_pkg;

  // architecture family of the core feeding the classifier
  typedef enum logic [1:0] {
    TEC_ARCH_A32_LEGACY = 2'h0,
    TEC_ARCH_NEW_32     = 2'h1,
    TEC_ARCH_NEW_64     = 2'h2,
    TEC_ARCH_MCU        = 2'h3
  } tec_arch_type;

  // cause of the exception as reported by the core
  typedef enum logic [4:0] {
    TEC_C_RESET       = 5'h00,
    TEC_C_IRQ         = 5'h01,
    TEC_C_FIQ         = 5'h02,
    TEC_C_UNDEF       = 5'h03,
    TEC_C_CTRL_TRAP   = 5'h04,
    TEC_C_CALL_SUP    = 5'h05,
    TEC_C_CALL_HYP    = 5'h06,
    TEC_C_CALL_MON    = 5'h07,
    TEC_C_INST_ABORT  = 5'h08,
    TEC_C_BREAKPOINT_INSTR_INSTR  = 5'h09,
    TEC_C_HW_BREAKPOINT_INSTR     = 5'h0a,
    TEC_C_VEC_CATCH   = 5'h0b,
    TEC_C_STEP        = 5'h0c,
    TEC_C_DATA_ABORT  = 5'h0d,
    TEC_C_WATCHPOINT  = 5'h0e,
    TEC_C_PC_MISALIGN = 5'h0f,
    TEC_C_SP_MISALIGN = 5'h10,
    TEC_C_SYS_ERROR   = 5'h11,
    TEC_C_DEBUG_HALT  = 5'h12,
    TEC_C_NMI         = 5'h13,
    TEC_C_ESC_FAULT   = 5'h14,
    TEC_C_MEM_MGMT    = 5'h15,
    TEC_C_BUS_FAULT   = 5'h16,
    TEC_C_USAGE       = 5'h17,
    TEC_C_DBG_MON     = 5'h18,
    TEC_C_PEND_SV     = 5'h19,
    TEC_C_SYSTICK     = 5'h1a,
    TEC_C_LAZY_FP     = 5'h1b,
    TEC_C_LOCKUP      = 5'h1c,
    TEC_C_ECC         = 5'h1d,
    TEC_C_REPLAY      = 5'h1e,
    TEC_C_WAIT        = 5'h1f
  } tec_cause_type;

  // trace exception type reported to the element encoder
  typedef enum logic [4:0] {
    TEC_T_RESET      = 5'h00,
    TEC_T_IRQ        = 5'h01,
    TEC_T_FIQ        = 5'h02,
    TEC_T_TRAP       = 5'h03,
    TEC_T_CALL       = 5'h04,
    TEC_T_INST_FAULT = 5'h05,
    TEC_T_DATA_FAULT = 5'h06,
    TEC_T_INST_DEBUG = 5'h07,
    TEC_T_DATA_DEBUG = 5'h08,
    TEC_T_ALIGNMENT  = 5'h09,
    TEC_T_SYS_ERROR  = 5'h0a,
    TEC_T_DEBUG_HALT = 5'h0b,
    TEC_T_NMI        = 5'h0c,
    TEC_T_ESC_FAULT  = 5'h0d,
    TEC_T_MEM_MGMT   = 5'h0e,
    TEC_T_BUS_FAULT  = 5'h0f,
    TEC_T_USAGE      = 5'h10,
    TEC_T_DBG_MON    = 5'h11,
    TEC_T_SUP_CALL   = 5'h12,
    TEC_T_PEND_SV    = 5'h13,
    TEC_T_SYSTICK    = 5'h14,
    TEC_T_LAZY_FP    = 5'h15,
    TEC_T_LOCKUP     = 5'h16,
    TEC_T_ECC        = 5'h17,
    TEC_T_REPLAY     = 5'h18,
    TEC_T_WAIT       = 5'h19,
    TEC_T_IRQ_EXT    = 5'h1a
  } tec_type_type;

  // return address selection
  typedef enum logic [1:0] {
    TEC_RA_CURRENT = 2'h0,
    TEC_RA_NEXT    = 2'h1,
    TEC_RA_FIXED   = 2'h2,
    TEC_RA_NONE    = 2'h3
  } tec_ra_sel_type;

  localparam int          TEC_ADDR_W         = 64;
  localparam logic [63:0] TEC_TAIL_CHAIN_RA  = 64'h0000_0000_0fff_fffe;
  localparam logic [63:0] TEC_ICI_STEP_2     = 64'h0000_0000_0000_0002;
  localparam logic [63:0] TEC_ICI_STEP_4     = 64'h0000_0000_0000_0004;
  localparam logic [63:0] TEC_RESET_ADDR     = 64'h0000_0000_0000_0000;

endpackage

// ---- shared/tec_cls_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// decoded classification passed from the decoder to the output stage
interface tec_cls_if;
  import tec_pkg::*;
  tec_type_type   ex_type;
  tec_ra_sel_type ra_sel;
  logic           keep;
  modport dec (output ex_type, output ra_sel, output keep);
  modport use_side (input ex_type, input ra_sel, input keep);
endinterface
`default_nettype wire

// ---- verilog/tec_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module tec_decode
  import tec_pkg::*;
(
  input  wire tec_arch_type  i_arch,       // architecture family
  input  wire tec_cause_type i_cause,      // cause from core
  input  wire logic          i_bus_async,  // bus fault is imprecise
  input  wire logic          i_tail_chain, // mcu tail-chained entry
  input  wire logic          i_data_trace, // data tracing enabled
  input  wire logic          i_nonarch_en, // trace non-arch exceptions
  tec_cls_if.dec             cls           // classification out
);

  logic is64;
  logic mcu;

  always_comb begin
    is64        = (i_arch == TEC_ARCH_NEW_64);
    mcu         = (i_arch == TEC_ARCH_MCU);
    cls.ex_type = TEC_T_TRAP;
    cls.ra_sel  = TEC_RA_CURRENT;
    cls.keep    = 1'b1;
    unique case (i_cause)
      TEC_C_RESET: begin
        cls.ex_type = TEC_T_RESET;
        cls.ra_sel  = TEC_RA_NONE;                        // [R11]
      end
      TEC_C_IRQ: begin
        cls.ex_type = mcu ? TEC_T_IRQ_EXT : TEC_T_IRQ;
        cls.ra_sel  = TEC_RA_NEXT;                        // [R07]
      end
      TEC_C_FIQ: begin
        cls.ex_type = TEC_T_FIQ;
        cls.ra_sel  = TEC_RA_NEXT;                        // [R07]
      end
      // routed exceptions arrive as their own cause, so no routed type
      TEC_C_UNDEF, TEC_C_CTRL_TRAP: begin
        cls.ex_type = TEC_T_TRAP;                         // [R02] [R05] [R06]
        cls.ra_sel  = TEC_RA_CURRENT;                     // [R09]
      end
      TEC_C_CALL_SUP, TEC_C_CALL_HYP, TEC_C_CALL_MON: begin
        cls.ex_type = mcu ? TEC_T_SUP_CALL : TEC_T_CALL;  // [R14]
        cls.ra_sel  = TEC_RA_NEXT;                        // [R08]
      end
      TEC_C_INST_ABORT: begin
        cls.ex_type = TEC_T_INST_FAULT;                   // [R03]
        cls.ra_sel  = TEC_RA_CURRENT;                     // [R10]
      end
      TEC_C_BREAKPOINT_INSTR_INSTR, TEC_C_HW_BREAKPOINT_INSTR, TEC_C_VEC_CATCH, TEC_C_STEP: begin
        cls.ex_type = is64 ? TEC_T_INST_DEBUG             // [R04]
                           : TEC_T_INST_FAULT;            // [R03]
        cls.ra_sel  = TEC_RA_CURRENT;                     // [R10]
      end
      TEC_C_DATA_ABORT: begin
        cls.ex_type = TEC_T_DATA_FAULT;                   // [R03]
        cls.ra_sel  = TEC_RA_CURRENT;                     // [R10]
      end
      TEC_C_WATCHPOINT: begin
        cls.ex_type = is64 ? TEC_T_DATA_DEBUG             // [R04]
                           : TEC_T_DATA_FAULT;            // [R03]
        cls.ra_sel  = TEC_RA_CURRENT;                     // [R10]
      end
      TEC_C_PC_MISALIGN, TEC_C_SP_MISALIGN: begin
        cls.ex_type = TEC_T_ALIGNMENT;                    // [R04]
        cls.ra_sel  = TEC_RA_CURRENT;                     // [R10]
      end
      TEC_C_SYS_ERROR: begin
        // precision not guaranteed, analyzer must allow slack
        cls.ex_type = TEC_T_SYS_ERROR;                    // [R12]
        cls.ra_sel  = TEC_RA_NEXT;                        // [R07]
      end
      TEC_C_DEBUG_HALT: begin
        cls.ex_type = TEC_T_DEBUG_HALT;
        cls.ra_sel  = TEC_RA_NEXT;                        // [R07]
      end
      TEC_C_NMI: begin
        cls.ex_type = TEC_T_NMI;
        cls.ra_sel  = TEC_RA_NEXT;
      end
      TEC_C_ESC_FAULT: begin
        cls.ex_type = TEC_T_ESC_FAULT;
        cls.ra_sel  = TEC_RA_NEXT;
      end
      TEC_C_MEM_MGMT: begin
        cls.ex_type = TEC_T_MEM_MGMT;
        cls.ra_sel  = TEC_RA_CURRENT;                     // [R13]
      end
      TEC_C_BUS_FAULT: begin
        cls.ex_type = TEC_T_BUS_FAULT;
        cls.ra_sel  = i_bus_async ? TEC_RA_NEXT           // [R13]
                                  : TEC_RA_CURRENT;
      end
      TEC_C_USAGE: begin
        cls.ex_type = TEC_T_USAGE;
        cls.ra_sel  = TEC_RA_CURRENT;                     // [R13]
      end
      TEC_C_DBG_MON: begin
        cls.ex_type = TEC_T_DBG_MON;
        cls.ra_sel  = TEC_RA_NEXT;
      end
      TEC_C_PEND_SV: begin
        cls.ex_type = TEC_T_PEND_SV;
        cls.ra_sel  = TEC_RA_NEXT;
      end
      TEC_C_SYSTICK: begin
        cls.ex_type = TEC_T_SYSTICK;
        cls.ra_sel  = TEC_RA_NEXT;
      end
      TEC_C_LAZY_FP: begin
        cls.ex_type = TEC_T_LAZY_FP;
        cls.ra_sel  = TEC_RA_NEXT;
        cls.keep    = i_data_trace;                       // [R17]
      end
      TEC_C_LOCKUP: begin
        // lockup address arrives on the current-address input
        cls.ex_type = TEC_T_LOCKUP;
        cls.ra_sel  = TEC_RA_CURRENT;
      end
      TEC_C_ECC, TEC_C_REPLAY: begin
        cls.ex_type = (i_cause == TEC_C_ECC) ? TEC_T_ECC : TEC_T_REPLAY;
        cls.ra_sel  = TEC_RA_NEXT;                        // [R19]
        cls.keep    = i_nonarch_en;                       // [R18]
      end
      TEC_C_WAIT: begin
        // when off, progress shows via the next waypoint after restart
        cls.ex_type = TEC_T_WAIT;
        cls.ra_sel  = TEC_RA_NEXT;                        // [R19]
        cls.keep    = i_nonarch_en;                       // [R18] [R21]
      end
    endcase
    if (mcu && i_tail_chain && i_cause != TEC_C_RESET) begin
      cls.ra_sel = TEC_RA_FIXED;                          // [R15]
    end
  end

endmodule
`default_nettype wire

// ---- verilog/tec_classifier.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R01] each taken exception while tracing emits flag, type and return address
// [R02] undefined or control-trapped instructions are reported as trap type
// [R03] 32-bit: aborts, breakpoints, vector catch inst fault; data abort data
// [R04] 64-bit: debug events get debug types, misalignment gets alignment
// [R05] routed exceptions keep their normal type
// [R06] other control-bit traps are reported as trap type
// [R07] asynchronous types return to instruction after last executed one
// [R08] call types return to instruction after the call
// [R09] trap returns to trapped or causing instruction
// [R10] fault, debug and alignment types return to faulting instruction
// [R11] reset return address unknown; no execution implied since last waypoint
// [R12] system error return point is imprecise
// [R13] mcu bus faults precise or next; memory and usage faults faulting
// [R14] mcu supervisor call returns to instruction after the call
// [R15] mcu tail-chained exceptions report the fixed no-execution address
// [R16] interrupted continuable instruction reports address plus 2 or 4
// [R17] lazy float push traced only with data tracing on
// [R18] non-architectural exceptions optional, enabled by a control input
// [R19] non-architectural exceptions return after last executed instruction
// [R20] analyzer must not expect exception return after non-arch exception
// [R21] wait exception may be replaced by next waypoint after restart
// [R22] type and address appear with the element valid, in order
module tec_classifier
  import tec_pkg::*;
(
  input  wire  logic                  i_sys_clk,     // system clock
  input  wire  logic                  i_sys_rst,     // async reset, high
  input  wire  logic                  i_trace_en,    // tracing enabled
  input  wire  logic                  i_data_trace,  // data trace enabled
  input  wire  logic                  i_nonarch_en,  // trace non-arch
  input  wire  tec_arch_type          i_arch,        // architecture family
  input  wire  logic                  i_ex_taken,    // exception taken pulse
  input  wire  tec_cause_type         i_ex_cause,    // exception cause
  input  wire  logic                  i_bus_async,   // async bus fault
  input  wire  logic                  i_tail_chain,  // tail-chained entry
  input  wire  logic [TEC_ADDR_W-1:0] i_cur_addr,    // faulting/lockup addr
  input  wire  logic [TEC_ADDR_W-1:0] i_next_addr,   // after last executed
  input  wire  logic                  i_ici_active,  // nonzero continuation
  input  wire  logic                  i_ici_step4,   // 32-bit, +4 step
  output logic                        o_elem_valid,  // element pulse
  output tec_type_type                o_elem_type,   // exception type
  output logic [TEC_ADDR_W-1:0]       o_elem_addr,   // return address
  output logic                        o_elem_addr_ok,// address is known
  output logic                        o_elem_no_exec // no execution implied
);

  tec_cls_if cls ();

  tec_decode u_decode (
    .i_arch       (i_arch),
    .i_cause      (i_ex_cause),
    .i_bus_async  (i_bus_async),
    .i_tail_chain (i_tail_chain),
    .i_data_trace (i_data_trace),
    .i_nonarch_en (i_nonarch_en),
    .cls          (cls)
  );

  logic                  valid_d;
  logic                  valid_q;
  tec_type_type          type_d;
  tec_type_type          type_q;
  logic [TEC_ADDR_W-1:0] addr_d;
  logic [TEC_ADDR_W-1:0] addr_q;
  logic                  addr_ok_d;
  logic                  addr_ok_q;
  logic                  no_exec_d;
  logic                  no_exec_q;
  logic [TEC_ADDR_W-1:0] ici_addr;

  // continuation only alters next-address (TEC_RA_NEXT) entries on the mcu
  always_comb begin
    ici_addr = i_cur_addr + (i_ici_step4 ? TEC_ICI_STEP_4
                                         : TEC_ICI_STEP_2);  // [R16]
  end

  // one registered stage; each taken pulse with tracing on and cls.keep set yields its own element, so
  // back-to-back exceptions leave in the order they arrived
  always_comb begin
    valid_d   = i_ex_taken && i_trace_en && cls.keep;      // [R01] [R22]
    type_d    = type_q;
    addr_d    = addr_q;
    addr_ok_d = addr_ok_q;
    no_exec_d = no_exec_q;
    if (valid_d) begin
      type_d    = cls.ex_type;                               // [R22]
      addr_ok_d = 1'b1;
      no_exec_d = 1'b0;
      unique case (cls.ra_sel)
        TEC_RA_CURRENT: addr_d = i_cur_addr;                 // [R09] [R10]
        TEC_RA_NEXT: begin
          if (i_arch == TEC_ARCH_MCU && i_ici_active &&
              cls.ra_sel == TEC_RA_NEXT) begin
            addr_d = ici_addr;                               // [R16]
          end else begin
            addr_d = i_next_addr;                            // [R07] [R08]
          end
        end
        TEC_RA_FIXED: begin
          addr_d    = TEC_TAIL_CHAIN_RA;                     // [R15]
          no_exec_d = 1'b1;
        end
        TEC_RA_NONE: begin
          addr_d    = TEC_RESET_ADDR;                        // [R11]
          addr_ok_d = 1'b0;
          no_exec_d = 1'b1;                                  // [R11]
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      valid_q   <= 1'b0;
      type_q    <= TEC_T_RESET;
      addr_q    <= TEC_RESET_ADDR;
      addr_ok_q <= 1'b0;
      no_exec_q <= 1'b0;
    end else begin
      valid_q   <= valid_d;
      type_q    <= type_d;
      addr_q    <= addr_d;
      addr_ok_q <= addr_ok_d;
      no_exec_q <= no_exec_d;
    end
  end

  assign o_elem_valid   = valid_q;
  assign o_elem_type    = type_q;
  assign o_elem_addr    = addr_q;
  assign o_elem_addr_ok = addr_ok_q;
  assign o_elem_no_exec = no_exec_q;

endmodule
`default_nettype wire

// ---- bench/tec_classifier_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module tec_classifier_props
  import tec_pkg::*;
(
  input wire logic                  i_sys_clk,      // clock
  input wire logic                  i_sys_rst,      // reset
  input wire logic                  i_trace_en,     // trace on
  input wire logic                  i_data_trace,   // data trace on
  input wire tec_arch_type          i_arch,         // family
  input wire logic                  i_ex_taken,     // pulse
  input wire tec_cause_type         i_ex_cause,     // cause
  input wire logic                  i_tail_chain,   // tail chain
  input wire logic                  i_ici_active,   // continuation
  input wire logic                  i_ici_step4,    // +4 step
  input wire logic [TEC_ADDR_W-1:0] i_cur_addr,     // faulting
  input wire logic [TEC_ADDR_W-1:0] i_next_addr,    // next
  input wire logic                  o_elem_valid,   // element
  input wire tec_type_type          o_elem_type,    // type
  input wire logic [TEC_ADDR_W-1:0] o_elem_addr,    // address
  input wire logic                  o_elem_addr_ok, // known
  input wire logic                  o_elem_no_exec  // no exec
);
  logic tk;
  assign tk = i_ex_taken && i_trace_en;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_irq;
    tk && i_ex_cause == TEC_C_IRQ;
  endsequence
  sequence s_gap;
    o_elem_valid ##1 !o_elem_valid;
  endsequence
  property p_async;
    s_irq ##0 i_arch != TEC_ARCH_MCU |=> o_elem_valid
      && o_elem_type == TEC_T_IRQ && o_elem_addr == $past(i_next_addr);
  endproperty
  a_async: assert property (p_async) else $error("irq wrong");
  property p_off;
    !i_trace_en |=> !o_elem_valid;
  endproperty
  a_off: assert property (p_off) else $error("element while off");
  property p_lazy;
    tk && i_ex_cause == TEC_C_LAZY_FP && !i_data_trace |=> !o_elem_valid;
  endproperty
  a_lazy: assert property (p_lazy) else $error("lazy push not gated");
  property p_trap;
    tk && i_arch != TEC_ARCH_MCU
      && i_ex_cause inside {TEC_C_UNDEF, TEC_C_CTRL_TRAP}
      |=> o_elem_type == TEC_T_TRAP && o_elem_addr == $past(i_cur_addr);
  endproperty
  a_trap: assert property (p_trap) else $error("trap wrong");
  property p_call;
    tk && i_arch != TEC_ARCH_MCU
      && i_ex_cause inside {TEC_C_CALL_SUP, TEC_C_CALL_HYP, TEC_C_CALL_MON}
      |=> o_elem_type == TEC_T_CALL && o_elem_addr == $past(i_next_addr);
  endproperty
  a_call: assert property (p_call) else $error("call wrong");
  property p_dbg;
    tk && i_arch == TEC_ARCH_NEW_64 && i_ex_cause inside
      {TEC_C_BREAKPOINT_INSTR_INSTR, TEC_C_HW_BREAKPOINT_INSTR, TEC_C_VEC_CATCH, TEC_C_STEP}
      |=> o_elem_type == TEC_T_INST_DEBUG && o_elem_addr == $past(i_cur_addr);
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug wrong");
  property p_tail;
    s_irq ##0 i_arch == TEC_ARCH_MCU && i_tail_chain
      |=> o_elem_addr == TEC_TAIL_CHAIN_RA && o_elem_no_exec;
  endproperty
  a_tail: assert property (p_tail) else $error("tail chain wrong");
  property p_ici;
    s_irq ##0 i_arch == TEC_ARCH_MCU && !i_tail_chain && i_ici_active
      |=> o_elem_addr == $past(i_cur_addr)
      + ($past(i_ici_step4) ? TEC_ICI_STEP_4 : TEC_ICI_STEP_2);
  endproperty
  a_ici: assert property (p_ici) else $error("continuation wrong");
  property p_rst;
    tk && i_ex_cause == TEC_C_RESET
      |=> o_elem_valid && !o_elem_addr_ok && o_elem_no_exec;
  endproperty
  a_rst: assert property (p_rst) else $error("reset element wrong");
  property p_hold;
    s_gap |-> $stable(o_elem_type) && $stable(o_elem_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("element not held");
endmodule
bind tec_classifier tec_classifier_props u_props (.*);
`default_nettype wire

// ---- bench/tec_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tec_core_model
  import tec_pkg::*;
(
  input  wire logic            i_sys_clk, // clock
  output logic                 o_taken,   // exception pulse
  output tec_cause_type        o_cause,   // cause
  output logic [TEC_ADDR_W-1:0] o_cur,    // faulting address
  output logic [TEC_ADDR_W-1:0] o_next    // next address
);
  initial begin
    o_taken = 1'h0;
    o_cause = TEC_C_IRQ;
    o_cur = '0;
    o_next = '0;
  end
  task automatic fire(input tec_cause_type c,
                      input logic [TEC_ADDR_W-1:0] cur,
                      input logic [TEC_ADDR_W-1:0] nxt);
    @(negedge i_sys_clk);
    o_taken = 1'h1;
    o_cause = c;
    o_cur = cur;
    o_next = nxt;
  endtask
  // qualifiers are not held past the pulse, so stale values cannot pass
  task automatic idle;
    @(negedge i_sys_clk);
    o_taken = 1'h0;
    o_cause = tec_cause_type'(~o_cause);
    o_cur = ~o_cur;
    o_next = ~o_next;
  endtask
endmodule
`default_nettype wire

// ---- bench/tec_classifier_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module tec_classifier_test;
  import tec_pkg::*;
  logic i_sys_clk, i_sys_rst, i_trace_en, i_data_trace, i_nonarch_en;
  logic i_ex_taken, i_bus_async, i_tail_chain, i_ici_active, i_ici_step4;
  logic o_elem_valid, o_elem_addr_ok, o_elem_no_exec;
  tec_arch_type          i_arch;
  tec_cause_type         i_ex_cause;
  tec_type_type          o_elem_type;
  logic [TEC_ADDR_W-1:0] i_cur_addr, i_next_addr, o_elem_addr;
  logic [TEC_ADDR_W-1:0] ad = 64'hffff_0000_0000_1000;
  logic [TEC_ADDR_W-1:0] nx = 64'hffff_0000_0000_1004;
  logic                  e_ok = 1'h1;
  logic                  e_ne = 1'h0;
  int                    n_errors = 0;
  int                    num_checks = 0;

  tec_classifier u_dut (.*);
  tec_core_model u_core (.i_sys_clk(i_sys_clk), .o_taken(i_ex_taken),
    .o_cause(i_ex_cause), .o_cur(i_cur_addr), .o_next(i_next_addr));

  initial begin
    i_sys_clk = 1'h0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic elem(input tec_type_type ty, input logic [63:0] ea);
    chk(64'(o_elem_valid), 64'h1);
    chk(64'(o_elem_type), 64'(ty));
    chk(o_elem_addr, ea);
    chk(64'({o_elem_addr_ok, o_elem_no_exec}), 64'({e_ok, e_ne}));
  endtask
  task automatic ex(input tec_cause_type c, input tec_type_type ty,
                    input logic [63:0] ea);
    u_core.fire(c, ad, nx);
    u_core.idle();
    elem(ty, ea);
    ad = ad + 64'h0000_0000_0000_0130;
    nx = ad + 64'h0000_0000_0000_0004;
  endtask
  task automatic drop(input tec_cause_type c);
    u_core.fire(c, ad, nx);
    u_core.idle();
    chk(64'(o_elem_valid), 64'h0);
  endtask
  task automatic t_a32;
    for (int a = 0; a < 2; a++) begin
      i_arch = tec_arch_type'(a);
      ex(TEC_C_UNDEF, TEC_T_TRAP, ad);
      ex(TEC_C_CTRL_TRAP, TEC_T_TRAP, ad);
      ex(TEC_C_CALL_SUP, TEC_T_CALL, nx);
      ex(TEC_C_CALL_HYP, TEC_T_CALL, nx);
      ex(TEC_C_CALL_MON, TEC_T_CALL, nx);
      ex(TEC_C_INST_ABORT, TEC_T_INST_FAULT, ad);
      ex(TEC_C_BREAKPOINT_INSTR_INSTR, TEC_T_INST_FAULT, ad);
      ex(TEC_C_HW_BREAKPOINT_INSTR, TEC_T_INST_FAULT, ad);
      ex(TEC_C_VEC_CATCH, TEC_T_INST_FAULT, ad);
      ex(TEC_C_DATA_ABORT, TEC_T_DATA_FAULT, ad);
      ex(TEC_C_WATCHPOINT, TEC_T_DATA_FAULT, ad);
      ex(TEC_C_IRQ, TEC_T_IRQ, nx);
      ex(TEC_C_FIQ, TEC_T_FIQ, nx);
      ex(TEC_C_SYS_ERROR, TEC_T_SYS_ERROR, nx);
      ex(TEC_C_DEBUG_HALT, TEC_T_DEBUG_HALT, nx);
    end
    $display("test a32 done, errors %0d", n_errors);
  endtask
  task automatic t_a64;
    i_arch = TEC_ARCH_NEW_64;
    ex(TEC_C_BREAKPOINT_INSTR_INSTR, TEC_T_INST_DEBUG, ad);
    ex(TEC_C_HW_BREAKPOINT_INSTR, TEC_T_INST_DEBUG, ad);
    ex(TEC_C_VEC_CATCH, TEC_T_INST_DEBUG, ad);
    ex(TEC_C_STEP, TEC_T_INST_DEBUG, ad);
    ex(TEC_C_WATCHPOINT, TEC_T_DATA_DEBUG, ad);
    ex(TEC_C_PC_MISALIGN, TEC_T_ALIGNMENT, ad);
    ex(TEC_C_SP_MISALIGN, TEC_T_ALIGNMENT, ad);
    ex(TEC_C_INST_ABORT, TEC_T_INST_FAULT, ad);
    ex(TEC_C_DATA_ABORT, TEC_T_DATA_FAULT, ad);
    ex(TEC_C_UNDEF, TEC_T_TRAP, ad);
    $display("test a64 done, errors %0d", n_errors);
  endtask
  task automatic t_mcu;
    i_arch = TEC_ARCH_MCU;
    ex(TEC_C_NMI, TEC_T_NMI, nx);
    ex(TEC_C_ESC_FAULT, TEC_T_ESC_FAULT, nx);
    ex(TEC_C_MEM_MGMT, TEC_T_MEM_MGMT, ad);
    ex(TEC_C_USAGE, TEC_T_USAGE, ad);
    ex(TEC_C_BUS_FAULT, TEC_T_BUS_FAULT, ad);
    i_bus_async = 1'h1;
    ex(TEC_C_BUS_FAULT, TEC_T_BUS_FAULT, nx);
    i_bus_async = 1'h0;
    ex(TEC_C_CALL_SUP, TEC_T_SUP_CALL, nx);
    ex(TEC_C_DBG_MON, TEC_T_DBG_MON, nx);
    ex(TEC_C_PEND_SV, TEC_T_PEND_SV, nx);
    ex(TEC_C_SYSTICK, TEC_T_SYSTICK, nx);
    ex(TEC_C_LOCKUP, TEC_T_LOCKUP, ad);
    ex(TEC_C_DEBUG_HALT, TEC_T_DEBUG_HALT, nx);
    ex(TEC_C_IRQ, TEC_T_IRQ_EXT, nx);
    i_ici_active = 1'h1;
    ex(TEC_C_IRQ, TEC_T_IRQ_EXT, ad + TEC_ICI_STEP_2);
    i_ici_step4 = 1'h1;
    ex(TEC_C_IRQ, TEC_T_IRQ_EXT, ad + TEC_ICI_STEP_4);
    i_ici_active = 1'h0;
    i_tail_chain = 1'h1;
    e_ne = 1'h1;
    ex(TEC_C_IRQ, TEC_T_IRQ_EXT, TEC_TAIL_CHAIN_RA);
    i_tail_chain = 1'h0;
    e_ne = 1'h0;
    $display("test mcu done, errors %0d", n_errors);
  endtask
  task automatic t_gate;
    i_arch = TEC_ARCH_A32_LEGACY;
    i_trace_en = 1'h0;
    drop(TEC_C_IRQ);
    i_trace_en = 1'h1;
    drop(TEC_C_LAZY_FP);
    drop(TEC_C_ECC);
    i_data_trace = 1'h1;
    i_nonarch_en = 1'h1;
    ex(TEC_C_LAZY_FP, TEC_T_LAZY_FP, nx);
    // core sends no exception return after non-arch entries
    ex(TEC_C_ECC, TEC_T_ECC, nx);
    ex(TEC_C_REPLAY, TEC_T_REPLAY, nx);
    ex(TEC_C_WAIT, TEC_T_WAIT, nx);
    e_ok = 1'h0;
    e_ne = 1'h1;
    ex(TEC_C_RESET, TEC_T_RESET, TEC_RESET_ADDR);
    e_ok = 1'h1;
    e_ne = 1'h0;
    $display("test gate done, errors %0d", n_errors);
  endtask
  // two pulses on adjacent edges: order and hold of the second
  task automatic t_b2b;
    i_arch = TEC_ARCH_NEW_32;
    u_core.fire(TEC_C_IRQ, ad, nx);
    u_core.fire(TEC_C_UNDEF, nx, ad);
    elem(TEC_T_IRQ, nx);
    u_core.idle();
    elem(TEC_T_TRAP, nx);
    @(negedge i_sys_clk);
    chk(64'(o_elem_valid), 64'h0);
    chk(o_elem_addr, nx);
    $display("test b2b done, errors %0d", n_errors);
  endtask
  // mid-run reset must clear a held tail-chain element
  task automatic t_rst;
    @(negedge i_sys_clk);
    i_sys_rst = 1'h1;
    @(negedge i_sys_clk);
    chk(64'(o_elem_valid), 64'h0);
    chk(64'(o_elem_type), 64'(TEC_T_RESET));
    chk(o_elem_addr, TEC_RESET_ADDR);
    chk(64'({o_elem_addr_ok, o_elem_no_exec}), 64'h0);
    i_sys_rst = 1'h0;
    $display("test rst done, errors %0d", n_errors);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    i_sys_rst = 1'h1;
    i_trace_en = 1'h1;
    i_data_trace = 1'h0;
    i_nonarch_en = 1'h0;
    i_arch = TEC_ARCH_A32_LEGACY;
    i_bus_async = 1'h0;
    i_tail_chain = 1'h0;
    i_ici_active = 1'h0;
    i_ici_step4 = 1'h0;
    repeat (16) @(negedge i_sys_clk);
    i_sys_rst = 1'h0;
    t_a32();
    t_a64();
    t_mcu();
    t_rst();
    t_gate();
    t_b2b();
    complete_run();
  end
  // about 66 exceptions of two cycles each; far below this span
  initial begin
    #200_000;
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
